// ---- touch_adc_regs.svh ----
`ifndef TOUCH_ADC_REGS_SVH
`define TOUCH_ADC_REGS_SVH
// Notes on behaviour
// - Basic conversion spans three eight-clock transfers, 24 serial clocks.
// - Once mux and reference bits are known, acquire and enable needed drivers.
// - Three clocks later enter conversion, hold sample, drivers off if single-ended.
// - Twelve clocks after the control byte perform the conversion.
// - Differential mode keeps drivers on; host gives a 13th clock.
// - Serial output is low during the three trailing clocks, which are ignored.
// - Serial input is ignored until a high start bit, the byte's MSB.
// - Three channel bits pick mux input, drivers and reference connection.
// - Bit 3 low gives 12-bit, high gives 8-bit resolution.
// - Reference bit high is single-ended, low is differential ratiometric.
// - Channel 000 turns on the low-current temperature diode.
// - Channel 111 turns on the 91x high-current temperature diode.
// - Diode bias is on only during the three acquisition clocks.
// - Battery divider is on only while sampling channel 010.
// - Fifteen-clock mode overlaps conversions, drivers stay on until stopped; single-ended conversions turn them off at each hold.
// - New control byte every 15th clock in 12-bit, 11th in 8-bit.
// - Power bits: 11 all on, 00 down between, 01 ADC only, 10 ref only.
// - Reference power setting is latched when busy rises.
// - With power bit 0 clear, pen interrupt re-enables at end of conversion.
`define CB_START 7
`define CB_CHAN_HI 6
`define CB_CHAN_LO 4
`define CB_MODE 3
`define CB_REF 2
`define CB_PWR_HI 1
`define CB_PWR_LO 0
`define CHAN_DIODE_LOW_CURRENT 3'h0
`define CHAN_YPOS 3'h1
`define CHAN_BAT 3'h2
`define CHAN_Z1 3'h3
`define CHAN_Z2 3'h4
`define CHAN_XPOS 3'h5
`define CHAN_DIODE_HIGH_CURRENT 3'h7
`define CTRL_BITS 4'h8
`define ACQ_START 4'h5
`define ACQ_CHAN_HI 3
`define ACQ_CHAN_LO 1
`define OVERLAP_LEAD 4'h4
`define RES_BITS_12 4'hc
`define RES_BITS_8 4'h8
`endif

// ---- touch_adc_pkg.sv ----
package touch_adc_pkg;
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CTRL = 2'b01, ST_CONV = 2'b11} phase_e;
   typedef struct packed {
      logic [2:0] chanSelect;
      logic modeEight;
      logic refSelect;
      logic powerSelHi;
      logic powerSelLo;
   } ctrl_s;
   typedef struct packed {
      logic xDrvPos;
      logic xDrvNeg;
      logic yDrvPos;
      logic yDrvNeg;
   } drivers_s;
endpackage

// ---- edge_sync.sv ----
module edge_sync
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic asyncIn,
   output logic level,
   output logic rise,
   output logic fall
);
   typedef struct packed {
      logic [2:0] s;
      logic lvl;
   } sync_t;
   sync_t state_q, state_d;
   always_comb
   begin
      state_d = state_q;
      state_d.s = {state_q.s[1:0], asyncIn};
      // Stage two and three must agree before the level moves
      if (state_q.s[1] == state_q.s[2])
      begin
         state_d.lvl = state_q.s[2];
      end
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end
   assign level = state_q.lvl;
   assign rise = state_d.lvl & ~state_q.lvl;
   assign fall = ~state_d.lvl & state_q.lvl;
endmodule // edge_sync

// ---- touch_adc_ctrl.sv ----
`include "touch_adc_regs.svh"
module touch_adc_ctrl
#(
   parameter int RES_MAX = 12
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic convShiftClock,
   input wire logic serialIn,
   output logic serialOut,
   output logic busy,
   input wire logic [11:0] sampleResult,
   output logic sampleHold,
   output logic converting,
   output touch_adc_pkg::drivers_s drivers,
   output logic [2:0] muxChannel,
   output logic refDifferential,
   output logic diodeLowCurrent,
   output logic diodeHighCurrent,
   output logic batteryDivider,
   output logic refPowered,
   output logic adcPowered,
   output logic touchIrqEnable,
   output touch_adc_pkg::ctrl_s lastCtrl
);
   if (RES_MAX != 12)
   begin : gBadRes
      $error("touch_adc_ctrl supports only a 12-bit converter");
   end

   typedef struct packed {
      touch_adc_pkg::phase_e phase;
      logic [7:0] shiftIn;
      logic [3:0] bitCnt;
      logic [3:0] convCnt;
      logic [3:0] resBits;
      logic [11:0] result;
      touch_adc_pkg::ctrl_s ctrl;
      logic acquiring;
      logic holding;
      logic dout;
      logic busyLvl;
      logic refOn;
      logic irqEn;
   } state_t;
   state_t state_q, state_d;

   logic sclkRise;
   logic sclkFall;
   logic dinLevel;

   edge_sync sclkSync
   (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(convShiftClock),
      .level(),
      .rise(sclkRise),
      .fall(sclkFall)
   );

   edge_sync dinSync
   (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(serialIn),
      .level(dinLevel),
      .rise(),
      .fall()
   );

   touch_adc_pkg::ctrl_s partCtrl;
   logic [7:0] nextShift;

   always_comb
   begin
      state_d = state_q;
      nextShift = {state_q.shiftIn[6:0], dinLevel};
      partCtrl = state_q.ctrl;
      // Input sampled on rising edge
      if (sclkRise)
      begin
         case (state_q.phase)
            touch_adc_pkg::ST_IDLE:
            begin
               // Zeros before the start bit are dropped
               if (dinLevel)
               begin
                  state_d.phase = touch_adc_pkg::ST_CTRL;
                  state_d.shiftIn = 8'h01;
                  state_d.bitCnt = 4'h1;
               end
            end
            touch_adc_pkg::ST_CTRL:
            begin
               state_d.shiftIn = nextShift;
               state_d.bitCnt = state_q.bitCnt + 4'h1;
               if (state_q.bitCnt + 4'h1 == `ACQ_START)
               begin
                  // Channel known after the fifth bit: start sampling
                  state_d.ctrl.chanSelect = nextShift[`ACQ_CHAN_HI:`ACQ_CHAN_LO];
                  state_d.acquiring = 1'b1;
                  state_d.holding = 1'b0;
               end
               if (state_q.bitCnt + 4'h1 == `CTRL_BITS)
               begin
                  partCtrl.chanSelect = nextShift[`CB_CHAN_HI:`CB_CHAN_LO];
                  partCtrl.modeEight = nextShift[`CB_MODE];
                  partCtrl.refSelect = nextShift[`CB_REF];
                  partCtrl.powerSelHi = nextShift[`CB_PWR_HI];
                  partCtrl.powerSelLo = nextShift[`CB_PWR_LO];
                  state_d.ctrl = partCtrl;
                  state_d.phase = touch_adc_pkg::ST_CONV;
                  state_d.acquiring = 1'b0;
                  state_d.holding = 1'b1;
                  state_d.busyLvl = 1'b1;
                  // Reference power caught as busy rises
                  state_d.refOn = nextShift[`CB_PWR_HI];
                  state_d.irqEn = 1'b0;
                  state_d.convCnt = 4'h0;
                  state_d.resBits = nextShift[`CB_MODE] ? `RES_BITS_8 : `RES_BITS_12;
                  state_d.result = sampleResult;
               end
            end
            touch_adc_pkg::ST_CONV:
            begin
               // A high bit here starts the next byte: 15/11-clock overlap
               if (dinLevel && state_q.convCnt >= state_q.resBits - `OVERLAP_LEAD)
               begin
                  state_d.phase = touch_adc_pkg::ST_CTRL;
                  state_d.shiftIn = 8'h01;
                  state_d.bitCnt = 4'h1;
               end
            end
            default:
            begin
               state_d.phase = touch_adc_pkg::ST_IDLE;
            end
         endcase
      end
      // Output changes on falling edge
      if (sclkFall && state_q.busyLvl)
      begin
         if (state_q.convCnt < state_q.resBits)
         begin
            // First falling edge is the busy clock; data follow MSB first
            state_d.dout = (state_q.convCnt == 4'h0) ? 1'b0
               : state_q.result[`RES_BITS_12 - state_q.convCnt];
            state_d.convCnt = state_q.convCnt + 4'h1;
         end
         else
         begin
            state_d.dout = state_q.result[`RES_BITS_12 - state_q.resBits];
            state_d.busyLvl = 1'b0;
            state_d.holding = 1'b0;
            // End of conversion: pen detect returns if power bit 0 clear
            state_d.irqEn = ~state_q.ctrl.powerSelLo;
            if (state_q.phase == touch_adc_pkg::ST_CONV)
            begin
               state_d.phase = touch_adc_pkg::ST_IDLE;
            end
         end
      end
      else if (sclkFall && !state_q.busyLvl)
      begin
         state_d.dout = 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= '0;
         state_q.irqEn <= 1'b1;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   logic driveActive;
   logic keepOn;
   // Ratiometric conversions need the drivers on; single-ended ones release them at hold
   assign keepOn = ~state_q.ctrl.refSelect;
   assign driveActive = state_q.acquiring | (state_q.holding & keepOn);

   always_comb
   begin
      drivers = '0;
      if (driveActive)
      begin
         case (state_q.ctrl.chanSelect)
            `CHAN_YPOS:
            begin
               drivers.yDrvPos = 1'b1;
               drivers.yDrvNeg = 1'b1;
            end
            `CHAN_Z1, `CHAN_Z2:
            begin
               drivers.yDrvPos = 1'b1;
               drivers.xDrvNeg = 1'b1;
            end
            `CHAN_XPOS:
            begin
               drivers.xDrvPos = 1'b1;
               drivers.xDrvNeg = 1'b1;
            end
            default:
            begin
               drivers = '0;
            end
         endcase
      end
   end

   assign serialOut = state_q.dout;
   assign busy = state_q.busyLvl;
   assign sampleHold = state_q.holding;
   assign converting = state_q.busyLvl;
   assign muxChannel = state_q.ctrl.chanSelect;
   assign refDifferential = ~state_q.ctrl.refSelect;
   assign diodeLowCurrent = state_q.acquiring && state_q.ctrl.chanSelect == `CHAN_DIODE_LOW_CURRENT;
   assign diodeHighCurrent = state_q.acquiring && state_q.ctrl.chanSelect == `CHAN_DIODE_HIGH_CURRENT;
   assign batteryDivider = state_q.acquiring && state_q.ctrl.chanSelect == `CHAN_BAT;
   assign refPowered = state_q.refOn;
   assign adcPowered = state_q.ctrl.powerSelLo | state_q.busyLvl | state_q.acquiring;
   assign touchIrqEnable = state_q.irqEn & ~state_q.acquiring & ~state_q.busyLvl;
   assign lastCtrl = state_q.ctrl;
endmodule // touch_adc_ctrl

// ---- touch_adc_monitor.sv ----
module touch_adc_monitor
#(
   parameter int RES_MAX = 12
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic serialOut,
   input wire logic busy,
   input wire logic sampleHold,
   input wire logic converting,
   input wire touch_adc_pkg::drivers_s drivers,
   input wire logic [2:0] muxChannel,
   input wire logic refDifferential,
   input wire logic diodeLowCurrent,
   input wire logic diodeHighCurrent,
   input wire logic batteryDivider,
   input wire logic refPowered,
   input wire logic touchIrqEnable,
   input wire touch_adc_pkg::ctrl_s lastCtrl
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [5:0] idleQ;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Saturating idle count; long idle means the trailing low bits are long past
   always_ff @(posedge clk)
   begin
      if (!rst_n || busy)
         idleQ <= 6'h0;
      else if (idleQ != 6'h3f)
         idleQ <= idleQ + 6'h1;
   end
   busy_mirror_a: assert property (converting == busy)
      else $error("converting differs from busy");
   hold_on_conv_a: assert property ($rose(busy) |-> ##[0:2] sampleHold)
      else $error("no hold at conversion start");
   se_drivers_off_a: assert property (busy && !refDifferential |-> drivers == 4'h0)
      else $error("drivers on in single-ended conversion");
   diode_lo_a: assert property (diodeLowCurrent |-> muxChannel == 3'h0 && !busy)
      else $error("low diode bias misplaced");
   diode_hi_a: assert property (diodeHighCurrent |-> muxChannel == 3'h7 && !busy)
      else $error("high diode bias misplaced");
   bat_div_a: assert property (batteryDivider |-> muxChannel == 3'h2 && !busy)
      else $error("battery divider misplaced");
   ref_latched_a: assert property (busy && $past(busy) |-> $stable(refPowered))
      else $error("reference power moved while busy");
   idle_out_low_a: assert property (idleQ == 6'h3f |-> !serialOut)
      else $error("serial output high while idle");
   irq_en_cause_a: assert property ($rose(touchIrqEnable) |-> !lastCtrl.powerSelLo)
      else $error("pen detect enabled with power bit 0 set");
   cover property ($rose(busy) && refDifferential);
   cover property (diodeHighCurrent);
   cover property (batteryDivider);
   // Overlapped mode: next acquisition starts while the old result still shifts out
   cover property (busy && !sampleHold);
endmodule // touch_adc_monitor

bind touch_adc_ctrl touch_adc_monitor #(.RES_MAX(RES_MAX)) touch_adc_monitor_i (.clk, .rst_n,
   .serialOut, .busy, .sampleHold, .converting, .drivers, .muxChannel, .refDifferential,
   .diodeLowCurrent, .diodeHighCurrent, .batteryDivider, .refPowered, .touchIrqEnable,
   .lastCtrl);

// ---- serial_host.sv ----
module serial_host
(
   output logic convShiftClock,
   output logic serialIn,
   input wire logic serialOut
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] rxBits;
   initial
   begin
      convShiftClock = 1'h0;
      serialIn = 1'h0;
   end
   // Clock stands low between frames; data only moves while it is low
   task automatic frame(input logic [7:0] c, input int lead, input bit slow);
      for (int k = 0; k < lead + 24; k++)
      begin
         serialIn = (k >= lead && k < lead + 8) ? c[7 - (k - lead)] : 1'h0;
         #200;
         if (slow && k >= lead + 5 && k < lead + 8)
            #1500;
         convShiftClock = 1'h1;
         #200;
         rxBits = {rxBits[22:0], serialOut};
         convShiftClock = 1'h0;
      end
   endtask
   // Second control byte starts inside the first conversion's data phase
   task automatic pair(input logic [7:0] c1, input logic [7:0] c2, input int gap);
      for (int k = 0; k < gap + 24; k++)
      begin
         serialIn = (k < 8) ? c1[7 - k] : (k >= gap && k < gap + 8) ? c2[7 - (k - gap)] : 1'h0;
         #200;
         convShiftClock = 1'h1;
         #200;
         rxBits = {rxBits[22:0], serialOut};
         convShiftClock = 1'h0;
      end
   endtask
endmodule // serial_host

// ---- tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, convShiftClock, serialIn, serialOut, busy, sampleHold, converting;
   logic refDifferential, diodeLowCurrent, diodeHighCurrent, batteryDivider, refPowered;
   logic adcPowered, touchIrqEnable, sawLo, sawHi, sawBat, sawDrv, drvWas;
   logic [2:0] muxChannel;
   logic [11:0] sampleResult;
   logic [15:0] seed;
   touch_adc_pkg::drivers_s drivers;
   touch_adc_pkg::ctrl_s lastCtrl;
   int nFail, totalChecks, cycles, drvDrops;
   touch_adc_ctrl touch_adc_ctrl_i (.clk, .rst_n, .convShiftClock, .serialIn, .serialOut,
      .busy, .sampleResult, .sampleHold, .converting, .drivers, .muxChannel, .refDifferential,
      .diodeLowCurrent, .diodeHighCurrent, .batteryDivider, .refPowered, .adcPowered,
      .touchIrqEnable, .lastCtrl);
   serial_host serial_host_i (.convShiftClock, .serialIn, .serialOut);
   initial
   begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      sawLo |= diodeLowCurrent;
      sawHi |= diodeHighCurrent;
      sawBat |= batteryDivider;
      sawDrv |= busy && (drivers != 4'h0);
      // A gap in driver coverage shows up as an extra switch-off
      if (drvWas && drivers == 4'h0)
         drvDrops++;
      drvWas = (drivers != 4'h0);
      if (cycles == 40000)
      begin
         nFail++;
         summarize();
      end
   end
   function automatic logic [15:0] lfsr(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // One null bit after the control byte, then the result, then low filler
   function automatic logic [23:0] expRx(logic [11:0] r, logic m);
      return m ? {9'h0, r[11:4], 7'h0} : {9'h0, r, 3'h0};
   endfunction
   // Overlap: tail of the first result, three low bits, then the second result
   function automatic logic [23:0] expPair(logic [11:0] r, logic m);
      return m ? {r[9:4], 3'h0, r[11:4], 7'h0} : {r[5:0], 3'h0, r, 3'h0};
   endfunction
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      totalChecks++;
      if (got !== exp)
      begin
         nFail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic checkFlag(input logic got, input logic exp);
      check({23'h0, got}, {23'h0, exp});
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic runFrame(input logic [7:0] c, input int lead, input bit slow);
      logic [2:0] ch;
      ch = c[6:4];
      seed = lfsr(seed);
      @(posedge clk);
      #2;
      sampleResult = seed[11:0];
      {sawLo, sawHi, sawBat, sawDrv} = 4'h0;
      serial_host_i.frame(c, lead, slow);
      repeat (12) @(posedge clk);
      #2;
      check(serial_host_i.rxBits, expRx(seed[11:0], c[3]));
      check({17'h0, lastCtrl}, {17'h0, c[6:0]});
      check({21'h0, muxChannel}, {21'h0, ch});
      checkFlag(refDifferential, ~c[2]);
      checkFlag(refPowered, c[1]);
      checkFlag(adcPowered, c[0]);
      checkFlag(touchIrqEnable, ~c[0]);
      if (c[2])
      begin
         checkFlag(sawLo, ch == 3'h0);
         checkFlag(sawHi, ch == 3'h7);
         checkFlag(sawBat, ch == 3'h2);
      end
      if (c[2] || ch inside {3'h1, 3'h3, 3'h4, 3'h5})
         checkFlag(sawDrv, ~c[2]);
   endtask
   // Two ratiometric Y conversions, the first keeps the ADC powered, the last powers the ADC down
   task automatic runPair(input logic m);
      logic [7:0] c1;
      logic [7:0] c2;
      seed = lfsr(seed);
      c1 = {1'h1, 3'h1, m, 1'h0, 1'h0, 1'h1};
      c2 = {1'h1, 3'h1, m, 1'h0, seed[0], 1'h0};
      @(posedge clk);
      #2;
      sampleResult = seed[11:0];
      drvDrops = 0;
      serial_host_i.pair(c1, c2, m ? 11 : 15);
      repeat (12) @(posedge clk);
      #2;
      check(serial_host_i.rxBits, expPair(seed[11:0], m));
      check({17'h0, lastCtrl}, {17'h0, c2[6:0]});
      check(24'(drvDrops), 24'h1);
      checkFlag(refPowered, c2[1]);
      checkFlag(touchIrqEnable, 1'h1);
   endtask
   initial
   begin
      rst_n = 1'h0;
      sampleResult = 12'h0;
      seed = 16'h0062;
      repeat (16) @(posedge clk);
      #2;
      rst_n = 1'h1;
      repeat (6) @(posedge clk);
      #2;
      checkFlag(busy, 1'h0);
      checkFlag(touchIrqEnable, 1'h1);
      for (int i = 0; i < 16; i++)
         runFrame({1'h1, i[2:0], i[0], ~i[3], i[1], i[3] ^ i[0]}, i % 3, i[2]);
      for (int i = 0; i < 24; i++)
      begin
         seed = lfsr(seed);
         runFrame({1'h1, seed[6:0]}, seed[9:8], seed[10]);
      end
      runPair(1'h0);
      runPair(1'h1);
      summarize();
   end
endmodule // tb
